// ### srl_pkg.sv
package srl_pkg;
   // Register byte addresses on the AXI4-Lite bus.
   localparam logic [3:0] SRL_CTRL0_ADDR = 4'h0;
   localparam logic [3:0] SRL_CTRL1_ADDR = 4'h4;
   localparam logic [3:0] SRL_STAT_ADDR  = 4'h8;
   // First control register fields.
   localparam int SRL_LEN_BIT  = 7;
   localparam int SRL_DIV_LSB  = 4;
   localparam int SRL_QEN_BIT  = 3;
   localparam int SRL_NQEN_BIT = 2;
   localparam int SRL_PS_BIT   = 1;
   localparam int SRL_PR_BIT   = 0;
   // Second control register fields, set enables high, reset enables low; SRL_SIE_BIT and SRL_RIE_BIT are status register bits.
   localparam int SRL_SPE_BIT  = 7;
   localparam int SRL_SCKE_BIT = 6;
   localparam int SRL_SC2E_BIT = 5;
   localparam int SRL_SC1E_BIT = 4;
   localparam int SRL_RPE_BIT  = 3;
   localparam int SRL_RCKE_BIT = 2;
   localparam int SRL_RC2E_BIT = 1;
   localparam int SRL_RC1E_BIT = 0;
   localparam int SRL_SIE_BIT  = 1;
   localparam int SRL_RIE_BIT  = 0;
   localparam logic [7:0] SRL_CTRL_RST = 8'h00;
   // Smallest divider is four system clocks, code 000.
   localparam int SRL_DIV_BASE_LOG2 = 2;
   localparam int SRL_DIV_CNT_W     = 9;
   localparam logic [1:0] SRL_RESP_OKAY   = 2'h0;
   localparam logic [1:0] SRL_RESP_SLVERR = 2'h2;
endpackage : srl_pkg

// ### srl_latch_unit.sv
// Notes on behaviour
// - The storage element is a level-sensitive latch, never clock sampled.
// - Combined set and reset inputs are both active high.
// - Set and reset together leave the latch reset.
// - Pulse set and pulse reset bits clear themselves after acting.
// - Writing one pulses its latch input one clock; writing zero does nothing.
// - Sources: software pulse, comparators one and two, input pin, divider.
// - Comparator outputs may be synchronised to the timer clock first.
// - Divider select picks pulse period from 4 to 512 clocks.
// - Divider source is a one-clock pulse each period, not a square wave.
// - Divider pulse reaches set or reset under independent enables.
// - True and inverted outputs have separate enables, may drive together.
// - Outputs reach pins only while latch enable is one.
// - Device reset leaves the latch state undefined.
// - Control zero: enable 7, divider 6:4, outputs 3:2, pulses 1:0.
module srl_latch_unit
   import srl_pkg::*;
(
   // Clock and reset.
   input  wire logic        mclk,
   input  wire logic        rst,
   // AXI4-Lite write address and data.
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read channels.
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Latch sources.
   input  wire logic        comparator1_output,
   input  wire logic        comparator2_output,
   input  wire logic        comparator1_synced_output,
   input  wire logic        comparator2_synced_output,
   input  wire logic        external_latch_input,
   // Latch outputs and their drive enables.
   output logic             true_output_pin,
   output logic             true_output_oe,
   output logic             inverted_output_pin,
   output logic             inverted_output_oe
);

   ////////////////////////////////////////////////////////////////////////
   // Register state.
   logic [7:0]  latch_control_zero_reg, latch_control_zero_next;
   logic [7:0]  latch_control_one_reg, latch_control_one_next;
   logic [1:0]  sync_sel_reg, sync_sel_next;
   logic        pset_reg, pset_next;
   logic        preset_reg, preset_next;
   logic        aw_held_reg, aw_held_next;
   logic [3:0]  aw_addr_reg, aw_addr_next;
   logic        w_held_reg, w_held_next;
   logic [31:0] w_data_reg, w_data_next;
   logic        w_strb0_reg, w_strb0_next;
   logic        bvalid_reg, bvalid_next;
   logic [1:0]  bresp_reg, bresp_next;
   logic        rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0]  rresp_reg, rresp_next;
   logic [SRL_DIV_CNT_W-1:0] div_cnt_reg, div_cnt_next;
   logic        div_pulse_reg, div_pulse_next;
   logic        do_write;
   logic        latch_q;
   logic        set_in, reset_in;
   logic        cmp1, cmp2;

   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready  = !w_held_reg && !bvalid_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

   ////////////////////////////////////////////////////////////////////////
   // Bus slave: address and data are taken in either order, the write
   // lands once both are held, so the response never overtakes either.
   always_comb begin
      aw_held_next = aw_held_reg;
      aw_addr_next = aw_addr_reg;
      w_held_next  = w_held_reg;
      w_data_next  = w_data_reg;
      w_strb0_next = w_strb0_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      do_write     = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_held_next = 1'b1;
         aw_addr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_held_next  = 1'b1;
         w_data_next  = s_axi_wdata;
         w_strb0_next = s_axi_wstrb[0];
      end
      if (aw_held_reg && w_held_reg) begin
         do_write     = 1'b1;
         aw_held_next = 1'b0;
         w_held_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = (aw_addr_reg == SRL_CTRL0_ADDR ||
                         aw_addr_reg == SRL_CTRL1_ADDR ||
                         aw_addr_reg == SRL_STAT_ADDR) ?
                        SRL_RESP_OKAY : SRL_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
   end

   // Control registers; the pulse bits never store, they only fire.
   always_comb begin
      latch_control_zero_next = latch_control_zero_reg;
      latch_control_one_next  = latch_control_one_reg;
      sync_sel_next           = sync_sel_reg;
      pset_next               = 1'b0;
      preset_next             = 1'b0;
      if (do_write && w_strb0_reg) begin
         unique case (aw_addr_reg)
            SRL_CTRL0_ADDR: begin
               latch_control_zero_next = {w_data_reg[7:2], 2'b00};
               pset_next   = w_data_reg[SRL_PS_BIT];
               preset_next = w_data_reg[SRL_PR_BIT];
            end
            SRL_CTRL1_ADDR: latch_control_one_next = w_data_reg[7:0];
            SRL_STAT_ADDR:  sync_sel_next          = w_data_reg[1:0];
            default: ;
         endcase
      end
   end

   // Read side: the pulse bits read as zero, the latch state is visible.
   always_comb begin
      rvalid_next = rvalid_reg;
      rdata_next  = rdata_reg;
      rresp_next  = rresp_reg;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_next = 1'b1;
         rresp_next  = SRL_RESP_OKAY;
         unique case (s_axi_araddr)
            SRL_CTRL0_ADDR: rdata_next = {24'h000000, latch_control_zero_reg};
            SRL_CTRL1_ADDR: rdata_next = {24'h000000, latch_control_one_reg};
            SRL_STAT_ADDR:  rdata_next = {23'h000000, latch_q, 6'h00,
                                          sync_sel_reg};
            default: begin
               rdata_next = 32'h00000000;
               rresp_next = SRL_RESP_SLVERR;
            end
         endcase
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Divider: a free counter; the pulse fires when its low bits wrap, so
   // the period is four shifted left by the select code.
   // The counter is never cleared on a change of code. That keeps the
   // logic small, but the first period after a change may be shorter
   // than the new code asks for. Every later period is exact, and two
   // pulses are never closer than four clocks.
   always_comb begin
      logic [SRL_DIV_CNT_W-1:0] mask;
      mask = SRL_DIV_CNT_W'((1 << (SRL_DIV_BASE_LOG2 +
             int'(latch_control_zero_reg[SRL_DIV_LSB +: 3]))) - 1);
      div_cnt_next   = div_cnt_reg + 1'b1;
      div_pulse_next = ((div_cnt_reg & mask) == mask);
   end

   // Registering of all clocked state.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         latch_control_zero_reg <= SRL_CTRL_RST;
         latch_control_one_reg  <= SRL_CTRL_RST;
         sync_sel_reg           <= 2'h0;
         pset_reg               <= 1'b0;
         preset_reg             <= 1'b0;
         aw_held_reg            <= 1'b0;
         aw_addr_reg            <= 4'h0;
         w_held_reg             <= 1'b0;
         w_data_reg             <= 32'h00000000;
         w_strb0_reg            <= 1'b0;
         bvalid_reg             <= 1'b0;
         bresp_reg              <= 2'h0;
         rvalid_reg             <= 1'b0;
         rdata_reg              <= 32'h00000000;
         rresp_reg              <= 2'h0;
         div_cnt_reg            <= '0;
         div_pulse_reg          <= 1'b0;
      end else begin
         latch_control_zero_reg <= latch_control_zero_next;
         latch_control_one_reg  <= latch_control_one_next;
         sync_sel_reg           <= sync_sel_next;
         pset_reg               <= pset_next;
         preset_reg             <= preset_next;
         aw_held_reg            <= aw_held_next;
         aw_addr_reg            <= aw_addr_next;
         w_held_reg             <= w_held_next;
         w_data_reg             <= w_data_next;
         w_strb0_reg            <= w_strb0_next;
         bvalid_reg             <= bvalid_next;
         bresp_reg              <= bresp_next;
         rvalid_reg             <= rvalid_next;
         rdata_reg              <= rdata_next;
         rresp_reg              <= rresp_next;
         div_cnt_reg            <= div_cnt_next;
         div_pulse_reg          <= div_pulse_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Source gating. The comparator path picks raw or timer-synchronised.
   assign cmp1 = sync_sel_reg[0] ? comparator1_synced_output
                                 : comparator1_output;
   assign cmp2 = sync_sel_reg[1] ? comparator2_synced_output
                                 : comparator2_output;

   // Combined active-high inputs, each an OR of enabled sources.
   always_comb begin
      set_in = (pset_reg & latch_control_one_reg[SRL_SPE_BIT]) |
               (div_pulse_reg & latch_control_one_reg[SRL_SCKE_BIT]) |
               (cmp2 & latch_control_one_reg[SRL_SC2E_BIT]) |
               (cmp1 & latch_control_one_reg[SRL_SC1E_BIT]) |
               (external_latch_input & sync_sel_reg[SRL_SIE_BIT] &
                latch_control_one_reg[SRL_SPE_BIT]);
      reset_in = (preset_reg & latch_control_one_reg[SRL_RPE_BIT]) |
               (div_pulse_reg & latch_control_one_reg[SRL_RCKE_BIT]) |
               (cmp2 & latch_control_one_reg[SRL_RC2E_BIT]) |
               (cmp1 & latch_control_one_reg[SRL_RC1E_BIT]) |
               (external_latch_input & sync_sel_reg[SRL_RIE_BIT] &
                latch_control_one_reg[SRL_RPE_BIT]);
   end

   // The storage element itself: transparent on its inputs, no clock and
   // no reset, so its value after power-up is whatever it settles to.
   // Hazard: a raw comparator level reaches the latch without any
   // retiming, so a glitch on it can flip the latch between clocks.
   always_latch begin
      if (reset_in)
         latch_q = 1'b0;
      else if (set_in)
         latch_q = 1'b1;
   end

   // Pin drive; firmware must still open the port direction bit.
   assign true_output_pin     = latch_q;
   assign inverted_output_pin = !latch_q;
   assign true_output_oe      = latch_control_zero_reg[SRL_LEN_BIT] &
                                latch_control_zero_reg[SRL_QEN_BIT];
   assign inverted_output_oe  = latch_control_zero_reg[SRL_LEN_BIT] &
                                latch_control_zero_reg[SRL_NQEN_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   a_pulse_one_cycle: assert property (@(posedge mclk) disable iff (rst)
      pset_reg |=> !pset_reg) else $error("set pulse longer than one cycle");
   a_pulse_from_write: assert property (@(posedge mclk) disable iff (rst)
      (do_write && w_strb0_reg && aw_addr_reg == SRL_CTRL0_ADDR &&
       w_data_reg[SRL_PS_BIT]) |=> pset_reg)
      else $error("set pulse missing after write");
   a_reset_wins: assert property (@(posedge mclk) disable iff (rst)
      reset_in |-> !latch_q) else $error("latch not reset");
   a_set_works: assert property (@(posedge mclk) disable iff (rst)
      (set_in && !reset_in) |-> latch_q) else $error("latch not set");
   a_oe_needs_len: assert property (@(posedge mclk) disable iff (rst)
      (true_output_oe || inverted_output_oe) |->
      latch_control_zero_reg[SRL_LEN_BIT])
      else $error("output driven while latch disabled");
   a_div_min_gap: assert property (@(posedge mclk) disable iff (rst)
      div_pulse_reg |=> !div_pulse_reg [*3])
      else $error("divider pulses too close");
   a_div_four: assert property (@(posedge mclk) disable iff (rst)
      (div_pulse_reg && latch_control_zero_reg[6:4] == 3'h0 &&
       $stable(latch_control_zero_reg)) |->
      ##4 (div_pulse_reg || latch_control_zero_reg[6:4] != 3'h0))
      else $error("divide by four period wrong");
   a_clk_gate: assert property (@(posedge mclk) disable iff (rst)
      (div_pulse_reg && !latch_control_one_reg[SRL_SCKE_BIT] &&
       latch_control_one_reg[7:4] == 4'h0) |-> !set_in)
      else $error("divider reached set while disabled");

   // With every reset enable off, a divider pulse must not reach the
   // reset input; the clock enables act on their own side only.
   a_div_rst_gate: assert property (@(posedge mclk) disable iff (rst)
      (div_pulse_reg && latch_control_one_reg[3:0] == 4'h0) |-> !reset_in)
      else $error("divider reached reset while disabled");

   // The reset pulse mirrors the set pulse: one cycle, fired by a write.
   a_rpulse_once: assert property (@(posedge mclk) disable iff (rst)
      preset_reg |=> !preset_reg)
      else $error("reset pulse longer than one cycle");
   a_rpulse_write: assert property (@(posedge mclk) disable iff (rst)
      (do_write && w_strb0_reg && aw_addr_reg == SRL_CTRL0_ADDR &&
       w_data_reg[SRL_PR_BIT]) |=> preset_reg)
      else $error("reset pulse missing after write");

   // Writing zero to the set pulse bit must leave the set pulse quiet.
   a_zero_no_pulse: assert property (@(posedge mclk) disable iff (rst)
      (do_write && w_strb0_reg && aw_addr_reg == SRL_CTRL0_ADDR &&
       !w_data_reg[SRL_PS_BIT]) |=> !pset_reg)
      else $error("set pulse after write of zero");

   // Once a pin is driven, the two outputs must be complementary.
   a_inv_follows: assert property (@(posedge mclk) disable iff (rst)
      (true_output_oe || inverted_output_oe) |->
      (inverted_output_pin != true_output_pin))
      else $error("inverted pin not complement of true pin");

   // Bus answers stand unchanged until the master takes them.
   a_bresp_hold: assert property (@(posedge mclk) disable iff (rst)
      (bvalid_reg && !s_axi_bready) |=> (bvalid_reg && $stable(bresp_reg)))
      else $error("write response dropped before taken");
   a_rdata_hold: assert property (@(posedge mclk) disable iff (rst)
      (rvalid_reg && !s_axi_rready) |=> (rvalid_reg && $stable(rdata_reg)))
      else $error("read data dropped before taken");
   a_pulse_bits_zero: assert property (@(posedge mclk) disable iff (rst)
      latch_control_zero_reg[1:0] == 2'b00)
      else $error("pulse bits stored");
   c_sw_set: cover property (@(posedge mclk) disable iff (rst)
      pset_reg ##1 latch_q);
   c_sw_reset: cover property (@(posedge mclk) disable iff (rst)
      preset_reg ##1 !latch_q);
   c_both_out: cover property (@(posedge mclk) disable iff (rst)
      true_output_oe && inverted_output_oe);
   c_div_set: cover property (@(posedge mclk) disable iff (rst)
      div_pulse_reg && latch_control_one_reg[SRL_SCKE_BIT]);
   c_div_reset: cover property (@(posedge mclk) disable iff (rst)
      div_pulse_reg && latch_control_one_reg[SRL_RCKE_BIT]);

endmodule : srl_latch_unit

// ### srl_src_model.sv
module srl_src_model (
   // Clock.
   input  wire logic       mclk,
   // Requested levels: bit 2 pin, bit 1 comparator two, bit 0 one.
   input  wire logic [2:0] level_req,
   // Source levels seen by the latch unit.
   output logic            comparator1_output,
   output logic            comparator2_output,
   output logic            comparator1_synced_output,
   output logic            comparator2_synced_output,
   output logic            external_latch_input
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] sync_reg;

   // Raw comparator and pin levels follow the request at once.
   assign comparator1_output = level_req[0];
   assign comparator2_output = level_req[1];
   assign external_latch_input = level_req[2];

   // Timer retiming lags one clock, so synced levels trail the raw ones.
   always_ff @(posedge mclk) begin
      sync_reg <= level_req[1:0];
   end
   assign comparator1_synced_output = sync_reg[0];
   assign comparator2_synced_output = sync_reg[1];
endmodule : srl_src_model

// ### srl_latch_unit_bench.sv
module srl_latch_unit_bench;
   import srl_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, rsp;
   logic [2:0]  level_req = 3'h0;
   logic        c1, c2, c1s, c2s, ext, q, q_oe, nq, nq_oe;
   logic [7:0]  c1r, ax, lv;
   int          bad_count = 0, comparisons = 0, cyc = 0;
   int          model_q = 0, r1, st, rs;
   integer      seed = 32'hE16B07C8;
   logic [1:0]  ps [4] = '{2'h2, 2'h1, 2'h2, 2'h3};

   // Clock and a free cycle count for timing the divider.
   always #50 mclk = ~mclk;
   always @(posedge mclk) cyc <= cyc + 1;

   srl_latch_unit i_srl_latch_unit (.mclk(mclk), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .comparator1_output(c1), .comparator2_output(c2),
      .comparator1_synced_output(c1s), .comparator2_synced_output(c2s),
      .external_latch_input(ext), .true_output_pin(q),
      .true_output_oe(q_oe), .inverted_output_pin(nq),
      .inverted_output_oe(nq_oe));
   srl_src_model i_srl_src_model (.mclk(mclk), .level_req(level_req),
      .comparator1_output(c1), .comparator2_output(c2),
      .comparator1_synced_output(c1s), .comparator2_synced_output(c2s),
      .external_latch_input(ext));

   ////////////////////////////////////////////////////////////////////////
   // Comparison and closing report.
   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         bad_count++;
      end
   endtask : check

   task automatic stop_test;
      $display("Counts: %0d compared, %0d bad", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : stop_test

   // A hung handshake is a mismatch, so no wait can stall the run.
   task automatic wait_guard(inout int n);
      n++;
      if (n > 2000) begin
         check("wait bound", 32'h0, 32'h1);
         stop_test();
      end
   endtask : wait_guard

   ////////////////////////////////////////////////////////////////////////
   // One bus cycle; handshakes sampled at the falling edge are the ones
   // that complete at the next rising edge, avoiding edge races.
   task automatic axi(input logic wr, input logic [3:0] a,
                      input logic [7:0] d);
      logic aw_h, w_h, b_h, ar_h, r_h;
      int   n;
      n = 0;
      if (wr) begin
         {awaddr, wdata, wstrb} <= {a, 24'h0, d, 4'hF};
         {awvalid, wvalid, bready} <= 3'h7;
      end else begin
         araddr <= a;
         {arvalid, rready} <= 2'h3;
      end
      do begin
         @(negedge mclk);
         {aw_h, w_h, b_h} = {awvalid & awready, wvalid & wready, bready & bvalid};
         {ar_h, r_h} = {arvalid & arready, rready & rvalid};
         if (b_h) rsp = bresp;
         if (r_h) {rd, rsp} = {rdata, rresp};
         @(posedge mclk);
         if (aw_h) awvalid <= 1'b0;
         if (w_h) wvalid <= 1'b0;
         if (b_h) bready <= 1'b0;
         if (ar_h) arvalid <= 1'b0;
         if (r_h) rready <= 1'b0;
         wait_guard(n);
      end while (awvalid || wvalid || bready || arvalid || rready);
   endtask : axi

   // Waits for the true output to rise and notes the cycle it was seen.
   task automatic wait_rise;
      int n;
      n = 0;
      do begin
         @(negedge mclk);
         r1 = cyc;
         wait_guard(n);
      end while (q !== 1'b1);
      @(posedge mclk);
   endtask : wait_rise

   ////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      axi(0, SRL_CTRL0_ADDR, 8'h00);
      check("ctrl0 reset", {24'h0, SRL_CTRL_RST}, rd);
      axi(0, SRL_CTRL1_ADDR, 8'h00);
      check("ctrl1 reset", 32'h0, rd);
      axi(0, 4'hC, 8'h00);
      check("unmapped resp", {30'h0, SRL_RESP_SLVERR}, {30'h0, rsp});
      check("unmapped data", 32'h0, rd);
      $display("Test register reset done");
      // Software pulses; the first one sets a known state.
      axi(1, SRL_CTRL1_ADDR, 8'h88);
      check("write resp", {30'h0, SRL_RESP_OKAY}, {30'h0, rsp});
      for (int t = 0; t < 4; t++) begin
         axi(1, SRL_CTRL0_ADDR, {6'h0, ps[t]});
         model_q = ps[t][0] ? 0 : 1;
         axi(0, SRL_CTRL0_ADDR, 8'h00);
         check("pulse bits", 32'h0, rd);
         axi(0, SRL_STAT_ADDR, 8'h00);
         check("pulse state", 32'(model_q), {31'h0, rd[8]});
         check("true pin", 32'(model_q), {31'h0, q});
      end
      $display("Test software pulses done");
      // Random sources and enables, clock enables kept off.
      for (int t = 0; t < 40; t++) begin
         level_req <= 3'h0;
         c1r = $random(seed) & 8'hBB;
         ax = $random(seed) & 8'h03;
         lv = $random(seed) & 8'h07;
         axi(1, SRL_CTRL1_ADDR, c1r);
         axi(1, SRL_STAT_ADDR, ax);
         level_req <= lv[2:0];
         repeat (3) @(posedge mclk);
         st = (c1r[4] & lv[0]) | (c1r[5] & lv[1]) | (c1r[7] & lv[2] & ax[1]);
         rs = (c1r[0] & lv[0]) | (c1r[1] & lv[1]) | (c1r[3] & lv[2] & ax[0]);
         model_q = rs ? 0 : (st ? 1 : model_q);
         axi(0, SRL_STAT_ADDR, 8'h00);
         check("source state", 32'(model_q), {31'h0, rd[8]});
      end
      $display("Test random sources done");
      // Every combination of enable and the two output enables.
      for (int t = 0; t < 8; t++) begin
         axi(1, SRL_CTRL0_ADDR, {t[2], 3'h0, t[1], t[0], 2'h0});
         check("true oe", {31'h0, t[2] & t[1]}, {31'h0, q_oe});
         check("inv oe", {31'h0, t[2] & t[0]}, {31'h0, nq_oe});
         check("inv pin", {31'h0, ~q}, {31'h0, nq});
      end
      $display("Test output enables done");
      // Divider sets, pin resets; rise to rise spacing is the period.
      level_req <= 3'h0;
      axi(1, SRL_CTRL1_ADDR, 8'h48);
      axi(1, SRL_STAT_ADDR, 8'h03);
      for (int code = 0; code < 8; code++) begin
         axi(1, SRL_CTRL0_ADDR, {1'b1, code[2:0], 4'h8});
         for (int k = 0; k < 2; k++) begin
            st = r1;
            level_req <= 3'h4;
            @(posedge mclk);
            level_req <= 3'h0;
            wait_rise();
         end
         check("divider period", 32'(4 << code), 32'(r1 - st));
      end
      $display("Test divider done");
      stop_test();
   end
endmodule : srl_latch_unit_bench
